// ---- rtl/epc_ctrl_regs.sv ----
// Purpose: write-side control registers of the energy pool
// Assumes: soc_pct and site_load_kw come from logic on clk
// Notes: registers are write-only; results show on the output ports
`timescale 1ns/1ns

module epc_ctrl_regs #(
  parameter longint TIMEOUT_CYC = epc_pkg::TIMEOUT_CYC,
  parameter logic [15:0] PMAX_NOM = epc_pkg::PMAX_NOM
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register writes
  input wire logic wr_valid,
  input wire logic [15:0] wr_addr,
  input wire logic [15:0] wr_data,
  output logic wr_ack_ff,
  output logic wr_err_ff,
  // plant measurements
  input wire logic [15:0] soc_pct,
  input wire logic [15:0] site_load_kw,
  // site controller requests
  output logic manual_active_ff,
  output logic sup_ctrl_en_ff,
  output epc_pkg::epc_cmd_t cmd_ff,
  output logic cmd_strobe_ff,
  output logic [15:0] p_set_ff,
  output logic [15:0] q_set_ff,
  output logic [15:0] pmax_ff,
  output logic [15:0] ramp_ff,
  // scheduler default timer
  output logic sched_run_ff,
  output logic [15:0] sched_mode_ff,
  output logic [15:0] chg_lim_ff,
  output logic [15:0] dis_lim_ff,
  output logic peak_shave_ff
);

  //////////////////////////////////////////////////////////////////////////////
  // address decode
  logic hit_op, hit_p, hit_q, hit_pmax, hit_ramp, hit_key;
  logic hit_tmr, hit_chg, hit_dis, hit_smin, hit_smax, hit_mode, hit_peak;
  logic hit_any, manual, tmr_ok, key_wr, man_exp, sch_exp;

  assign hit_op = wr_valid && (wr_addr == epc_pkg::A_OP_STATE);
  assign hit_p = wr_valid && (wr_addr == epc_pkg::A_P_SET);
  assign hit_q = wr_valid && (wr_addr == epc_pkg::A_Q_SET);
  assign hit_pmax = wr_valid && (wr_addr == epc_pkg::A_PMAX_SET);
  assign hit_ramp = wr_valid && (wr_addr == epc_pkg::A_RAMP_SET);
  assign hit_key = wr_valid && (wr_addr == epc_pkg::A_CTRL_KEY);
  assign hit_tmr = wr_valid && (wr_addr == epc_pkg::A_TMR_START);
  assign hit_chg = wr_valid && (wr_addr == epc_pkg::A_MAX_CHG);
  assign hit_dis = wr_valid && (wr_addr == epc_pkg::A_MAX_DIS);
  assign hit_smin = wr_valid && (wr_addr == epc_pkg::A_MIN_SOC);
  assign hit_smax = wr_valid && (wr_addr == epc_pkg::A_MAX_SOC);
  assign hit_mode = wr_valid && (wr_addr == epc_pkg::A_SCH_MODE);
  assign hit_peak = wr_valid && (wr_addr == epc_pkg::A_PEAK_THR);
  assign hit_any = hit_op | hit_p | hit_q | hit_pmax | hit_ramp | hit_key | hit_tmr
    | hit_chg | hit_dis | hit_smin | hit_smax | hit_mode | hit_peak;

  //////////////////////////////////////////////////////////////////////////////
  // stored request words
  logic [15:0] op_req_ff, p_req_ff, q_req_ff, pmax_req_ff, ramp_req_ff, key_ff;
  logic [15:0] chg_req_ff, dis_req_ff, smin_ff, smax_ff, mode_ff, peak_ff;
  logic [15:0] nxt_op_req, nxt_p_req, nxt_q_req, nxt_pmax_req, nxt_ramp_req, nxt_key;
  logic [15:0] nxt_chg_req, nxt_dis_req, nxt_smin, nxt_smax, nxt_mode, nxt_peak;
  logic nxt_ack, nxt_err;

  assign manual = (key_ff == epc_pkg::KEY_MANUAL);
  assign tmr_ok = !manual;
  assign key_wr = hit_key && (wr_data == epc_pkg::KEY_MANUAL);

  // next values of the request words
  always_comb
  begin
    nxt_op_req = hit_op ? wr_data : op_req_ff;
    nxt_p_req = hit_p ? wr_data : p_req_ff;
    nxt_q_req = hit_q ? wr_data : q_req_ff;
    nxt_pmax_req = hit_pmax ? wr_data : pmax_req_ff;
    nxt_ramp_req = hit_ramp ? wr_data : ramp_req_ff;
    nxt_chg_req = hit_chg ? wr_data : chg_req_ff;
    nxt_dis_req = hit_dis ? wr_data : dis_req_ff;
    nxt_smin = hit_smin ? wr_data : smin_ff;
    nxt_smax = hit_smax ? wr_data : smax_ff;
    nxt_mode = hit_mode ? wr_data : mode_ff;
    nxt_peak = hit_peak ? wr_data : peak_ff;
    // a key write in the expiry cycle wins over the clear
    nxt_key = key_ff;
    if (hit_key)
    begin
      nxt_key = wr_data;
    end
    else if (man_exp)
    begin
      nxt_key = epc_pkg::R_ZERO;
    end
    // timer writes under manual control are refused
    nxt_ack = hit_any && !(hit_tmr && !tmr_ok);
    nxt_err = wr_valid && !nxt_ack;
  end

  // register the request words
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      op_req_ff <= epc_pkg::R_ZERO;
      p_req_ff <= epc_pkg::R_ZERO;
      q_req_ff <= epc_pkg::R_ZERO;
      pmax_req_ff <= epc_pkg::R_ZERO;
      ramp_req_ff <= epc_pkg::R_ZERO;
      key_ff <= epc_pkg::R_ZERO;
      chg_req_ff <= epc_pkg::R_ZERO;
      dis_req_ff <= epc_pkg::R_ZERO;
      smin_ff <= epc_pkg::R_ZERO;
      smax_ff <= epc_pkg::R_ZERO;
      mode_ff <= epc_pkg::R_ZERO;
      peak_ff <= epc_pkg::R_ZERO;
      wr_ack_ff <= 1'b0;
      wr_err_ff <= 1'b0;
    end
    else
    begin
      op_req_ff <= nxt_op_req;
      p_req_ff <= nxt_p_req;
      q_req_ff <= nxt_q_req;
      pmax_req_ff <= nxt_pmax_req;
      ramp_req_ff <= nxt_ramp_req;
      key_ff <= nxt_key;
      chg_req_ff <= nxt_chg_req;
      dis_req_ff <= nxt_dis_req;
      smin_ff <= nxt_smin;
      smax_ff <= nxt_smax;
      mode_ff <= nxt_mode;
      peak_ff <= nxt_peak;
      wr_ack_ff <= nxt_ack;
      wr_err_ff <= nxt_err;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // session timers: manual control and scheduler timer
  epc_watchdog #(
    .LIMIT(TIMEOUT_CYC)
  ) u_man_wd (
    .clk(clk),
    .rst_b(rst_b),
    .run(manual),
    .kick(wr_valid),
    .expired_ff(man_exp)
  );

  epc_watchdog #(
    .LIMIT(TIMEOUT_CYC)
  ) u_sch_wd (
    .clk(clk),
    .rst_b(rst_b),
    .run(sched_run_ff),
    .kick(hit_tmr && tmr_ok && (wr_data == epc_pkg::TMR_START)),
    .expired_ff(sch_exp)
  );

  //////////////////////////////////////////////////////////////////////////////
  // forwarding to the site controller
  epc_pkg::epc_cmd_t nxt_cmd;
  logic nxt_strobe;
  logic [15:0] nxt_p_set, nxt_q_set, nxt_pmax, nxt_ramp;
  logic [31:0] abs_p, abs_q, q_lim;
  logic p_enough;

  // reactive limit from active power magnitude
  always_comb
  begin
    abs_p = p_req_ff[15] ? 32'(-$signed(p_req_ff)) : 32'(p_req_ff);
    abs_q = q_req_ff[15] ? 32'(-$signed(q_req_ff)) : 32'(q_req_ff);
    q_lim = (abs_p * epc_pkg::Q_RATIO_NUM) / epc_pkg::Q_RATIO_DEN;
    if (q_lim > epc_pkg::Q_CLAMP)
    begin
      q_lim = epc_pkg::Q_CLAMP;
    end
    p_enough = (abs_p * epc_pkg::PCT_FULL) >= (32'(nxt_pmax) * epc_pkg::MIN_P_PCT);
  end

  // next forwarded values
  always_comb
  begin
    nxt_cmd = cmd_ff;
    nxt_strobe = 1'b0;
    nxt_p_set = p_set_ff;
    nxt_q_set = q_set_ff;
    nxt_ramp = ramp_ff;
    // truncation holds in every mode
    nxt_pmax = (pmax_req_ff > PMAX_NOM) ? PMAX_NOM : pmax_req_ff;
    if (manual)
    begin
      nxt_p_set = p_req_ff;
      nxt_ramp = ramp_req_ff;
      if (!p_enough)
      begin
        nxt_q_set = epc_pkg::R_ZERO;
      end
      else if (abs_q > q_lim)
      begin
        nxt_q_set = q_req_ff[15] ? 16'(-q_lim) : q_lim[15:0];
      end
      else
      begin
        nxt_q_set = q_req_ff;
      end
      if (hit_op)
      begin
        nxt_strobe = 1'b1;
        case (wr_data)
          epc_pkg::C_GRID_TIED: nxt_cmd = epc_pkg::CMD_GRID_TIED;
          epc_pkg::C_AUTONOMOUS: nxt_cmd = epc_pkg::CMD_AUTONOMOUS;
          epc_pkg::C_BATT_BACKUP: nxt_cmd = epc_pkg::CMD_BATTERY_BACKUP;
          epc_pkg::C_POWER_UP: nxt_cmd = epc_pkg::CMD_POWER_UP;
          epc_pkg::C_BYPASS: nxt_cmd = epc_pkg::CMD_BYPASS;
          epc_pkg::C_DROP_LOADS: nxt_cmd = epc_pkg::CMD_DROP_LOADS;
          default: nxt_strobe = 1'b0;
        endcase
      end
    end
  end

  // register forwarded values
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd_ff <= epc_pkg::CMD_NONE;
      cmd_strobe_ff <= 1'b0;
      p_set_ff <= epc_pkg::R_ZERO;
      q_set_ff <= epc_pkg::R_ZERO;
      pmax_ff <= epc_pkg::R_ZERO;
      ramp_ff <= epc_pkg::R_ZERO;
      manual_active_ff <= 1'b0;
      sup_ctrl_en_ff <= 1'b1;
    end
    else
    begin
      cmd_ff <= nxt_cmd;
      cmd_strobe_ff <= nxt_strobe;
      p_set_ff <= nxt_p_set;
      q_set_ff <= nxt_q_set;
      pmax_ff <= nxt_pmax;
      ramp_ff <= nxt_ramp;
      manual_active_ff <= (nxt_key == epc_pkg::KEY_MANUAL);
      sup_ctrl_en_ff <= (nxt_key != epc_pkg::KEY_MANUAL);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // scheduler default timer
  epc_pkg::epc_sched_t sch_st_ff, nxt_sch_st;
  logic [15:0] nxt_chg_lim, nxt_dis_lim;
  logic nxt_peak_act, at_max, at_min;

  assign at_max = soc_pct >= smax_ff;
  assign at_min = soc_pct <= smin_ff;

  // timer state and limits
  always_comb
  begin
    nxt_sch_st = sch_st_ff;
    unique case (sch_st_ff)
      epc_pkg::SCH_IDLE:
      begin
        if (hit_tmr && tmr_ok && (wr_data == epc_pkg::TMR_START))
        begin
          nxt_sch_st = epc_pkg::SCH_RUN;
        end
      end
      epc_pkg::SCH_RUN:
      begin
        if (hit_tmr && tmr_ok && (wr_data == epc_pkg::TMR_STOP))
        begin
          nxt_sch_st = epc_pkg::SCH_IDLE;
        end
        else if (hit_tmr && tmr_ok && (wr_data == epc_pkg::TMR_START))
        begin
          nxt_sch_st = epc_pkg::SCH_RUN;
        end
        else if (sch_exp)
        begin
          nxt_sch_st = epc_pkg::SCH_IDLE;
        end
        else if ((mode_ff == epc_pkg::M_CHARGE) && at_max)
        begin
          nxt_sch_st = epc_pkg::SCH_IDLE;
        end
        else if ((mode_ff == epc_pkg::M_DISCHARGE) && at_min)
        begin
          nxt_sch_st = epc_pkg::SCH_IDLE;
        end
      end
    endcase
    // limits reach the converter only while running
    nxt_chg_lim = sched_run_ff ? chg_req_ff : epc_pkg::R_ZERO;
    nxt_dis_lim = sched_run_ff ? dis_req_ff : epc_pkg::R_ZERO;
    nxt_peak_act = sched_run_ff && (mode_ff == epc_pkg::M_PEAK_SHAVE)
      && ($signed(site_load_kw) > $signed({1'b0, peak_ff}));
  end

  // register timer state
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sch_st_ff <= epc_pkg::SCH_IDLE;
      sched_run_ff <= 1'b0;
      sched_mode_ff <= epc_pkg::R_ZERO;
      chg_lim_ff <= epc_pkg::R_ZERO;
      dis_lim_ff <= epc_pkg::R_ZERO;
      peak_shave_ff <= 1'b0;
    end
    else
    begin
      sch_st_ff <= nxt_sch_st;
      sched_run_ff <= (nxt_sch_st == epc_pkg::SCH_RUN);
      sched_mode_ff <= mode_ff;
      chg_lim_ff <= nxt_chg_lim;
      dis_lim_ff <= nxt_dis_lim;
      peak_shave_ff <= nxt_peak_act;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_key_wr;
    wr_valid && (wr_addr == epc_pkg::A_CTRL_KEY) && (wr_data == epc_pkg::KEY_MANUAL);
  endsequence

  sequence s_tmr_wr(logic [15:0] code);
    wr_valid && (wr_addr == epc_pkg::A_TMR_START) && (wr_data == code);
  endsequence

  a_manual_enter: assert property (s_key_wr |=> manual_active_ff && !sup_ctrl_en_ff)
    else $error("manual key did not take control");
  a_manual_leave: assert property (hit_key && !key_wr |=> !manual_active_ff)
    else $error("non-key write kept manual control");
  a_timeout_clear: assert property (man_exp && !hit_key |=> key_ff == epc_pkg::R_ZERO)
    else $error("manual timeout did not clear key");
  a_timer_refused: assert property (manual && hit_tmr |=> $stable(sch_st_ff))
    else $error("timer changed under manual control");
  a_timer_start: assert property (!manual ##0 s_tmr_wr(epc_pkg::TMR_START)
    |=> sched_run_ff ##1 chg_lim_ff == $past(chg_req_ff))
    else $error("start code did not run timer");
  a_timer_stop: assert property (!manual ##0 s_tmr_wr(epc_pkg::TMR_STOP)
    |=> !sched_run_ff ##1 chg_lim_ff == epc_pkg::R_ZERO)
    else $error("stop code did not stop timer");
  a_pmax_trunc: assert property (pmax_ff <= PMAX_NOM)
    else $error("max input power above nominal");
  a_charge_stop: assert property (sched_run_ff && (mode_ff == epc_pkg::M_CHARGE) && at_max
    && !hit_tmr && !sch_exp |=> !sched_run_ff)
    else $error("charge mode ran past max level");
  a_limits_idle: assert property (!sched_run_ff |=> dis_lim_ff == epc_pkg::R_ZERO)
    else $error("limit applied while timer stopped");
  a_peak_act: assert property (sched_run_ff && (mode_ff == epc_pkg::M_PEAK_SHAVE)
    && ($signed(site_load_kw) > $signed({1'b0, peak_ff})) |=> peak_shave_ff)
    else $error("peak shaving not activated");
  a_cmd_grid: assert property (manual && hit_op && (wr_data == epc_pkg::C_GRID_TIED)
    |=> cmd_strobe_ff && (cmd_ff == epc_pkg::CMD_GRID_TIED) ##1 !cmd_strobe_ff)
    else $error("grid-tied command not decoded");

endmodule : epc_ctrl_regs

// ---- rtl/epc_pkg.sv ----
// Purpose: constants and types for the energy pool control register bank
// Assumes: 16-bit register writes arrive already decoded from function 0x10
// Notes: addresses are register numbers, one 16-bit word each

package epc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register numbers
  localparam logic [15:0] A_OP_STATE = 16'h0001;
  localparam logic [15:0] A_P_SET = 16'h0002;
  localparam logic [15:0] A_Q_SET = 16'h0003;
  localparam logic [15:0] A_PMAX_SET = 16'h0004;
  localparam logic [15:0] A_RAMP_SET = 16'h0005;
  localparam logic [15:0] A_CTRL_KEY = 16'h000C;
  localparam logic [15:0] A_TMR_START = 16'h0021;
  localparam logic [15:0] A_MAX_CHG = 16'h0022;
  localparam logic [15:0] A_MAX_DIS = 16'h0023;
  localparam logic [15:0] A_MIN_SOC = 16'h0025;
  localparam logic [15:0] A_MAX_SOC = 16'h0026;
  localparam logic [15:0] A_SCH_MODE = 16'h0027;
  localparam logic [15:0] A_PEAK_THR = 16'h0028;
  localparam logic [15:0] R_ZERO = 16'h0000;

  //////////////////////////////////////////////////////////////////////////////
  // command and key codes
  localparam logic [15:0] C_GRID_TIED = 16'h0064;
  localparam logic [15:0] C_AUTONOMOUS = 16'h015A;
  localparam logic [15:0] C_BATT_BACKUP = 16'h00AF;
  localparam logic [15:0] C_POWER_UP = 16'h0166;
  localparam logic [15:0] C_BYPASS = 16'h00D3;
  localparam logic [15:0] C_DROP_LOADS = 16'h01DE;
  localparam logic [15:0] KEY_MANUAL = 16'h7AB7;
  localparam logic [15:0] TMR_START = 16'h0001;
  localparam logic [15:0] TMR_STOP = 16'h0002;
  localparam logic [15:0] M_CHARGE = 16'h0001;
  localparam logic [15:0] M_DISCHARGE = 16'h0002;
  localparam logic [15:0] M_PEAK_SHAVE = 16'h0003;
  localparam logic [15:0] M_SELF_USE = 16'h0004;

  //////////////////////////////////////////////////////////////////////////////
  // limits and timing
  localparam logic [15:0] PMAX_NOM = 16'h0BB8;
  localparam logic [31:0] MIN_P_PCT = 32'h0000000A;
  localparam logic [31:0] PCT_FULL = 32'h00000064;
  localparam logic [31:0] Q_RATIO_NUM = 32'h00000031;
  localparam logic [31:0] Q_RATIO_DEN = 32'h0000000A;
  localparam logic [31:0] Q_CLAMP = 32'h00007FFF;
  localparam longint TIMEOUT_S = 60;
  localparam longint CLK_HZ = 100_000_000;
  localparam longint TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
  localparam int TW = 34;

  // pool operating-state commands
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_GRID_TIED,
    CMD_AUTONOMOUS,
    CMD_BATTERY_BACKUP,
    CMD_POWER_UP,
    CMD_BYPASS,
    CMD_DROP_LOADS
  } epc_cmd_t;

  // scheduler default timer state
  typedef enum logic {
    SCH_IDLE,
    SCH_RUN
  } epc_sched_t;

endpackage : epc_pkg

// ---- rtl/epc_watchdog.sv ----
// Purpose: inactivity timer for a control session
// Assumes: kick and run come from logic on clk
// Notes: expired pulses one cycle after LIMIT idle cycles
`timescale 1ns/1ns

module epc_watchdog #(
  parameter longint LIMIT = epc_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // session control
  input wire logic run,
  input wire logic kick,
  output logic expired_ff
);

  logic [epc_pkg::TW-1:0] cnt_ff;
  logic [epc_pkg::TW-1:0] nxt_cnt;
  logic nxt_expired;
  localparam logic [epc_pkg::TW-1:0] LAST = epc_pkg::TW'(LIMIT - 1);

  // count idle cycles while the session runs
  always_comb
  begin
    nxt_cnt = cnt_ff + 1'b1;
    nxt_expired = 1'b0;
    if (!run || kick)
    begin
      nxt_cnt = '0;
    end
    else if (cnt_ff == LAST)
    begin
      nxt_cnt = '0;
      nxt_expired = 1'b1;
    end
  end

  // register the count
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_ff <= '0;
      expired_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      expired_ff <= nxt_expired;
    end
  end

endmodule : epc_watchdog

// ---- dv/epc_client_model.sv ----
// Purpose: remote control client that writes the bank one word per strobe
// Assumes: requests change on the falling edge, answer sampled after the taking edge
// Notes: GAP adds idle cycles after each word to model a slow client
`timescale 1ns/1ns

module epc_client_model #(
  parameter int GAP = 0
) (
  // clock
  input wire logic clk,
  // write request
  output logic wr_valid,
  output logic [15:0] wr_addr,
  output logic [15:0] wr_data,
  // write answer
  input wire logic wr_ack_ff,
  input wire logic wr_err_ff
);

  //////////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial
  begin
    wr_valid = 1'b0;
    wr_addr = 16'h0000;
    wr_data = 16'h0000;
  end

  // one word: strobe held over one rising edge, answer taken one cycle later
  task automatic wr(input logic [15:0] addr, input logic [15:0] data, output logic ack,
                    output logic err);
    @(negedge clk);
    wr_valid = 1'b1;
    wr_addr = addr;
    wr_data = data;
    @(negedge clk);
    wr_valid = 1'b0;
    wr_addr = ~addr;  // released bus shows no stale word
    wr_data = ~data;
    ack = wr_ack_ff;
    err = wr_err_ff;
    repeat (GAP) @(negedge clk);
  endtask : wr

endmodule : epc_client_model

// ---- dv/epc_ctrl_regs_tb.sv ----
// Purpose: self-checking bench for the control register bank
// Assumes: short inactivity limit of 50 cycles
// Notes: plant inputs driven on the falling edge
`timescale 1ns/1ns

module epc_ctrl_regs_tb;
  localparam longint TMO = 50;
  logic clk, rst_b, wr_valid, wr_ack_ff, wr_err_ff, manual_active_ff, sup_ctrl_en_ff;
  logic cmd_strobe_ff, sched_run_ff, peak_shave_ff;
  logic [15:0] wr_addr, wr_data, soc_pct, site_load_kw, p_set_ff, q_set_ff, pmax_ff;
  logic [15:0] ramp_ff, sched_mode_ff, chg_lim_ff, dis_lim_ff;
  epc_pkg::epc_cmd_t cmd_ff;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [15:0] codes [6] = '{epc_pkg::C_GRID_TIED, epc_pkg::C_AUTONOMOUS,
    epc_pkg::C_BATT_BACKUP, epc_pkg::C_POWER_UP, epc_pkg::C_BYPASS, epc_pkg::C_DROP_LOADS};
  epc_pkg::epc_cmd_t cmds [6] = '{epc_pkg::CMD_GRID_TIED, epc_pkg::CMD_AUTONOMOUS,
    epc_pkg::CMD_BATTERY_BACKUP, epc_pkg::CMD_POWER_UP, epc_pkg::CMD_BYPASS,
    epc_pkg::CMD_DROP_LOADS};

  //////////////////////////////////////////////////////////////////////////////
  // design and client
  epc_ctrl_regs #(.TIMEOUT_CYC(TMO)) i_dut (.clk(clk), .rst_b(rst_b),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .wr_ack_ff(wr_ack_ff),
    .wr_err_ff(wr_err_ff), .soc_pct(soc_pct), .site_load_kw(site_load_kw),
    .manual_active_ff(manual_active_ff), .sup_ctrl_en_ff(sup_ctrl_en_ff), .cmd_ff(cmd_ff),
    .cmd_strobe_ff(cmd_strobe_ff), .p_set_ff(p_set_ff), .q_set_ff(q_set_ff),
    .pmax_ff(pmax_ff), .ramp_ff(ramp_ff), .sched_run_ff(sched_run_ff),
    .sched_mode_ff(sched_mode_ff), .chg_lim_ff(chg_lim_ff), .dis_lim_ff(dis_lim_ff),
    .peak_shave_ff(peak_shave_ff));
  epc_client_model i_client (.clk(clk), .wr_valid(wr_valid), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_ack_ff(wr_ack_ff), .wr_err_ff(wr_err_ff));

  // clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // one word with its expected answer
  task automatic w(input logic [15:0] a, input logic [15:0] d, input logic bad);
    logic ack;
    logic err;
    i_client.wr(a, d, ack, err);
    chk(ack, !bad);
    chk(err, bad);
  endtask : w

  // stop, load all timer words, then start
  task automatic timer_setup(input logic [15:0] mode, input logic [15:0] thr);
    w(epc_pkg::A_TMR_START, epc_pkg::TMR_STOP, 1'b0);
    w(epc_pkg::A_MAX_CHG, 16'h0098, 1'b0);
    w(epc_pkg::A_MAX_DIS, 16'h0082, 1'b0);
    w(epc_pkg::A_MIN_SOC, 16'h000F, 1'b0);
    w(epc_pkg::A_MAX_SOC, 16'h005C, 1'b0);
    w(epc_pkg::A_SCH_MODE, mode, 1'b0);
    w(epc_pkg::A_PEAK_THR, thr, 1'b0);
    w(epc_pkg::A_TMR_START, epc_pkg::TMR_START, 1'b0);
  endtask : timer_setup

  task automatic wrap_up;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // hang guard, well beyond the expected run
  initial
  begin
    #60000;
    error_cnt++;
    wrap_up();
  end

  //////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial
  begin
    rst_b = 1'b0;
    soc_pct = 16'h005B;
    site_load_kw = 16'h0000;
    tick(8);
    rst_b = 1'b1;
    chk(sup_ctrl_en_ff, 1'b1);
    chk(cmd_ff, epc_pkg::CMD_NONE);
    w(16'h0006, 16'h1234, 1'b1);
    w(16'h0024, 16'h0001, 1'b1);
    // charge mode runs until the upper level
    timer_setup(epc_pkg::M_CHARGE, 16'h0010);
    chk(sched_run_ff, 1'b1);
    tick(1);
    chk(chg_lim_ff, 16'h0098);
    chk(dis_lim_ff, 16'h0082);
    tick(3);
    chk(sched_run_ff, 1'b1);
    soc_pct = 16'h005C;
    tick(3);
    chk(sched_run_ff, 1'b0);
    // discharge mode stops at the lower level
    timer_setup(epc_pkg::M_DISCHARGE, 16'h0010);
    chk(sched_run_ff, 1'b1);
    soc_pct = 16'h000F;
    tick(3);
    chk(sched_run_ff, 1'b0);
    chk(dis_lim_ff, 16'h0000);
    // peak shaving above the threshold only
    soc_pct = 16'h0032;
    timer_setup(epc_pkg::M_PEAK_SHAVE, 16'h0010);
    site_load_kw = 16'h0010;
    tick(3);
    chk(peak_shave_ff, 1'b0);
    site_load_kw = 16'h0011;
    tick(3);
    chk(peak_shave_ff, 1'b1);
    chk(sched_mode_ff, epc_pkg::M_PEAK_SHAVE);
    w(epc_pkg::A_TMR_START, epc_pkg::TMR_STOP, 1'b0);
    chk(sched_run_ff, 1'b0);
    // self use ignores the level bound, then lapses
    soc_pct = 16'h005C;
    timer_setup(epc_pkg::M_SELF_USE, 16'h0010);
    tick(4);
    chk(sched_run_ff, 1'b1);
    chk(sched_mode_ff, epc_pkg::M_SELF_USE);
    tick(60);
    chk(sched_run_ff, 1'b0);
    // manual session written as one block
    w(epc_pkg::A_TMR_START, epc_pkg::TMR_STOP, 1'b0);
    w(epc_pkg::A_OP_STATE, epc_pkg::C_GRID_TIED, 1'b0);
    w(epc_pkg::A_P_SET, 16'h0190, 1'b0);
    w(epc_pkg::A_Q_SET, 16'h0066, 1'b0);
    w(epc_pkg::A_PMAX_SET, 16'h0FFF, 1'b0);
    w(epc_pkg::A_RAMP_SET, 16'h0640, 1'b0);
    w(epc_pkg::A_CTRL_KEY, epc_pkg::KEY_MANUAL, 1'b0);
    chk(manual_active_ff, 1'b1);
    chk(sup_ctrl_en_ff, 1'b0);
    tick(1);
    chk(p_set_ff, 16'h0190);
    chk(q_set_ff, 16'h0066);
    chk(pmax_ff, 16'h0BB8);
    chk(ramp_ff, 16'h0640);
    w(epc_pkg::A_Q_SET, 16'hF060, 1'b0);
    tick(1);
    chk(q_set_ff, 16'hF858);
    w(epc_pkg::A_P_SET, 16'hFE70, 1'b0);
    tick(1);
    chk(p_set_ff, 16'hFE70);
    w(epc_pkg::A_P_SET, 16'h001E, 1'b0);
    tick(1);
    chk(q_set_ff, 16'h0000);
    w(epc_pkg::A_TMR_START, epc_pkg::TMR_START, 1'b1);
    chk(sched_run_ff, 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      w(epc_pkg::A_OP_STATE, codes[i], 1'b0);
      chk(cmd_strobe_ff, 1'b1);
      chk(cmd_ff, cmds[i]);
    end
    w(epc_pkg::A_OP_STATE, 16'h0065, 1'b0);
    chk(cmd_strobe_ff, 1'b0);
    chk(cmd_ff, epc_pkg::CMD_DROP_LOADS);
    // key refreshed inside the limit keeps the session
    tick(40);
    w(epc_pkg::A_CTRL_KEY, epc_pkg::KEY_MANUAL, 1'b0);
    tick(40);
    chk(manual_active_ff, 1'b1);
    tick(20);
    chk(manual_active_ff, 1'b0);
    chk(sup_ctrl_en_ff, 1'b1);
    // other key value ends the session at once
    w(epc_pkg::A_CTRL_KEY, epc_pkg::KEY_MANUAL, 1'b0);
    chk(manual_active_ff, 1'b1);
    w(epc_pkg::A_CTRL_KEY, 16'h7AB6, 1'b0);
    chk(manual_active_ff, 1'b0);
    // supervisor side holds P/Q/ramp setpoints, pmax still updates, no command strobe
    w(epc_pkg::A_OP_STATE, epc_pkg::C_GRID_TIED, 1'b0);
    chk(cmd_strobe_ff, 1'b0);
    chk(cmd_ff, epc_pkg::CMD_DROP_LOADS);
    w(epc_pkg::A_P_SET, 16'h0001, 1'b0);
    w(epc_pkg::A_PMAX_SET, 16'h0708, 1'b0);
    tick(1);
    chk(pmax_ff, 16'h0708);
    chk(p_set_ff, 16'h001E);
    wrap_up();
  end

endmodule : epc_ctrl_regs_tb
